// ### pdm_pkg.sv
package pdm_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] OFS_PIN_LEVELS  = 3'h0;
    localparam logic [2:0] OFS_OUT_LATCH   = 3'h1;
    localparam logic [2:0] OFS_DIRECTION   = 3'h2;
    localparam logic [2:0] OFS_PAD_CONFIG  = 3'h3;
    localparam logic [2:0] OFS_OPEN_DRAIN  = 3'h4;
    localparam logic [2:0] OFS_ANALOG_HIGH = 3'h5;
    localparam logic [2:0] OFS_MUX_CTRL    = 3'h6;
    // reset values
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    // pad configuration field positions
    localparam int PAD_D_PU   = 7;
    localparam int PAD_E_PU   = 6;
    localparam int PAD_F_PU   = 5;
    localparam int PAD_G_PU   = 4;
    localparam int PAD_CHARGE = 0;
    localparam logic [7:0] ANALOG_IMPL_MASK = 8'h7F;
    // mux control field positions
    localparam int MUX_PSP_EN    = 0;
    localparam int MUX_CCP_EN    = 1;
    localparam int MUX_PWM_EN    = 2;
    localparam int MUX_SER_EN    = 3;
    localparam int MUX_SER_SYNC  = 4;
    localparam int MUX_SHUT_TRI  = 5;
    localparam logic [7:0] MUX_IMPL_MASK = 8'h3F;
    // upper pin positions
    localparam int PIN_CCP = 4;
    localparam int PIN_B   = 5;
    localparam int PIN_C   = 6;
    localparam int PIN_D   = 7;
    // package variants
    typedef enum logic [1:0] {
        PDM_PKG_SMALL = 2'b00,
        PDM_PKG_MID   = 2'b01,
        PDM_PKG_LARGE = 2'b10
    } pdm_variant_e;
endpackage

// ### pdm_pin_if.sv
`timescale 1ns/1ps
interface pdm_pin_if;
    logic [3:0] drive_en;
    logic [3:0] drive_val;
    logic [3:0] psp_sel;
    modport ctrl (output drive_en, output drive_val, output psp_sel);
    modport pad (input drive_en, input drive_val, input psp_sel);
endinterface

// ### pdm_pin_sel.sv
`timescale 1ns/1ps
module pdm_pin_sel (
    // register state
    input  wire logic [7:0] dir,
    input  wire logic [7:0] latch,
    input  wire logic [7:0] mux,
    // peripheral outputs
    input  wire logic       ccp_out,
    input  wire logic [3:0] pwm_out,
    input  wire logic       pwm_shutdown,
    input  wire logic       ser_tx,
    input  wire logic       ser_clk_out,
    input  wire logic       ser_data_out,
    input  wire logic       ser_data_drive,
    input  wire logic [3:0] psp_out,
    input  wire logic       psp_drive,
    // selection result
    pdm_pin_if.ctrl         sel
);
    // per pin precedence: slave port, then peripherals, then latch
    always_comb begin
        logic psp_on;
        logic pwm_on;
        logic ser_on;
        logic sync_on;
        logic tri_off;
        psp_on  = mux[pdm_pkg::MUX_PSP_EN];
        pwm_on  = mux[pdm_pkg::MUX_PWM_EN];
        ser_on  = mux[pdm_pkg::MUX_SER_EN];
        sync_on = mux[pdm_pkg::MUX_SER_SYNC];
        tri_off = pwm_on && pwm_shutdown && mux[pdm_pkg::MUX_SHUT_TRI];
        sel.psp_sel = {4{psp_on}};
        for (int i = 0; i < 4; i++) begin
            sel.drive_en[i]  = ~dir[i + pdm_pkg::PIN_CCP]; // R1
            sel.drive_val[i] = latch[i + pdm_pkg::PIN_CCP]; // R1
            if (pwm_on) begin
                sel.drive_val[i] = pwm_out[i]; // R4 R5
                if (tri_off) begin
                    sel.drive_en[i] = 1'b0; // R4 R5
                end
            end
        end
        if (!pwm_on && mux[pdm_pkg::MUX_CCP_EN]) begin
            sel.drive_val[0] = ccp_out; // R3
        end
        if (ser_on) begin
            sel.drive_val[2] = sync_on ? ser_clk_out : ser_tx; // R7 R8
            sel.drive_en[2]  = ~dir[pdm_pkg::PIN_C]; // R8
            if (sync_on) begin
                sel.drive_val[3] = ser_data_out; // R10
                sel.drive_en[3]  = ser_data_drive; // R10
            end else begin
                sel.drive_en[3] = ~dir[pdm_pkg::PIN_D];
            end
        end
        if (psp_on) begin
            sel.drive_en  = {4{psp_drive}}; // R6 R13
            sel.drive_val = psp_out; // R6 R13
        end
    end
endmodule

// ### pdm_port_mux.sv
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: direction bit clear drives latch; set samples pin into port register.
// R2: every pin comes up as an input after reset.
// R3: fifth pin carries compare/PWM output when output, feeds capture when input.
// R4: PWM channels A and B override latch; tri-state on shutdown.
// R5: PWM channels C and D drive seventh and eighth pins; tri-state allowed.
// R6: slave port enabled makes upper pins data lines, ignoring direction bits.
// R7: serial transmit drives seventh pin over latch when direction bit clear.
// R8: sync mode seventh pin is serial clock, out or in by direction.
// R9: direction set feeds eighth pin to serial receive input.
// R10: sync mode eighth pin carries serial data, serial port drives it.
// R11: pull-up bits missing on smaller variants are unimplemented, read zero.
// R12: pull-up off bit, output direction, or reset switch pull-ups off.
// R13: precedence is slave port, then peripheral outputs, then latch data.
module pdm_port_mux (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // package variant strap
    input  wire logic [1:0] variant,
    // register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // pads
    input  wire logic [7:0] pad_in,
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe,
    output logic      [7:0] pad_pullup,
    output logic      [7:0] pad_open_drain,
    // capture/compare unit
    input  wire logic       ccp_out,
    output logic            ccp_capture_in,
    // enhanced pwm
    input  wire logic [3:0] pwm_out,
    input  wire logic       pwm_shutdown,
    // second serial port
    input  wire logic       ser_tx,
    input  wire logic       ser_clk_out,
    input  wire logic       ser_data_out,
    input  wire logic       ser_data_drive,
    output logic            ser_clk_in,
    output logic            ser_rx_in,
    // parallel slave port
    input  wire logic [3:0] psp_out,
    input  wire logic       psp_drive,
    output logic      [3:0] psp_in,
    // pad and analog configuration
    output logic            charge_unit_data_select,
    output logic      [7:0] analog_select
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] port_d_output_latch_ff;
    logic [7:0] port_d_direction_ff;
    logic [7:0] pad_config_one_ff;
    logic [7:0] open_drain_control_ff;
    logic [7:0] analog_select_high_ff;
    logic [7:0] mux_ctrl_ff;
    logic [7:0] port_d_pin_levels_ff;
    logic [7:0] nxt_pad_cfg;
    logic [7:0] nxt_oe;
    logic [7:0] nxt_out;
    pdm_pin_if  upper ();

    // mask of pad config bits present on the given variant
    function automatic logic [7:0] pad_mask(input logic [1:0] v);
        logic [7:0] m;
        m = '0;
        m[pdm_pkg::PAD_CHARGE] = 1'b1;
        if (v != pdm_pkg::PDM_PKG_SMALL) begin
            m[pdm_pkg::PAD_D_PU] = 1'b1; // R11
            m[pdm_pkg::PAD_E_PU] = 1'b1; // R11
        end
        if (v == pdm_pkg::PDM_PKG_LARGE) begin
            m[pdm_pkg::PAD_F_PU] = 1'b1; // R11
            m[pdm_pkg::PAD_G_PU] = 1'b1; // R11
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // output latch
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            port_d_output_latch_ff <= pdm_pkg::RST_ZERO;
        end else if (reg_wr && (reg_addr == pdm_pkg::OFS_PIN_LEVELS ||
                                reg_addr == pdm_pkg::OFS_OUT_LATCH)) begin
            port_d_output_latch_ff <= reg_wdata; // R1
        end
    end

    // direction register, all inputs on reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            port_d_direction_ff <= pdm_pkg::RST_DIRECTION; // R2
        end else if (reg_wr && reg_addr == pdm_pkg::OFS_DIRECTION) begin
            port_d_direction_ff <= reg_wdata;
        end
    end

    // pad configuration, unimplemented bits held at zero
    assign nxt_pad_cfg = reg_wdata & pad_mask(variant); // R11
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pad_config_one_ff <= pdm_pkg::RST_ZERO;
        end else if (reg_wr && reg_addr == pdm_pkg::OFS_PAD_CONFIG) begin
            pad_config_one_ff <= nxt_pad_cfg;
        end else begin
            pad_config_one_ff <= pad_config_one_ff & pad_mask(variant); // R11
        end
    end

    // open drain and analog select
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            open_drain_control_ff <= pdm_pkg::RST_ZERO;
            analog_select_high_ff <= pdm_pkg::RST_ZERO;
        end else if (reg_wr && reg_addr == pdm_pkg::OFS_OPEN_DRAIN) begin
            open_drain_control_ff <= reg_wdata;
        end else if (reg_wr && reg_addr == pdm_pkg::OFS_ANALOG_HIGH) begin
            analog_select_high_ff <= reg_wdata & pdm_pkg::ANALOG_IMPL_MASK;
        end
    end

    // function enables for the upper pins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mux_ctrl_ff <= pdm_pkg::RST_ZERO;
        end else if (reg_wr && reg_addr == pdm_pkg::OFS_MUX_CTRL) begin
            mux_ctrl_ff <= reg_wdata & pdm_pkg::MUX_IMPL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // upper pin selection
    pdm_pin_sel u_sel (
        .dir            (port_d_direction_ff),
        .latch          (port_d_output_latch_ff),
        .mux            (mux_ctrl_ff),
        .ccp_out        (ccp_out),
        .pwm_out        (pwm_out),
        .pwm_shutdown   (pwm_shutdown),
        .ser_tx         (ser_tx),
        .ser_clk_out    (ser_clk_out),
        .ser_data_out   (ser_data_out),
        .ser_data_drive (ser_data_drive),
        .psp_out        (psp_out),
        .psp_drive      (psp_drive),
        .sel            (upper.ctrl)
    );

    // lower pins are plain latch outputs
    assign nxt_oe  = {upper.drive_en, ~port_d_direction_ff[3:0]}; // R1
    assign nxt_out = {upper.drive_val, port_d_output_latch_ff[3:0]}; // R1

    // registered pad drive and pull-ups
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pad_oe         <= pdm_pkg::RST_ZERO; // R2
            pad_out        <= pdm_pkg::RST_ZERO;
            pad_pullup     <= pdm_pkg::RST_ZERO; // R12
            pad_open_drain <= pdm_pkg::RST_ZERO;
        end else begin
            pad_oe         <= nxt_oe;
            pad_out        <= nxt_out;
            pad_pullup     <= {8{~pad_config_one_ff[pdm_pkg::PAD_D_PU]}} & ~nxt_oe; // R12
            pad_open_drain <= open_drain_control_ff;
        end
    end

    // pin sampling and peripheral inputs
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            port_d_pin_levels_ff <= pdm_pkg::RST_ZERO;
            ccp_capture_in       <= 1'b0;
            ser_clk_in           <= 1'b0;
            ser_rx_in            <= 1'b0;
            psp_in               <= '0;
        end else begin
            port_d_pin_levels_ff <= pad_in; // R1
            ccp_capture_in       <= pad_in[pdm_pkg::PIN_CCP]; // R3
            ser_clk_in           <= pad_in[pdm_pkg::PIN_C]; // R8
            ser_rx_in            <= pad_in[pdm_pkg::PIN_D]; // R9 R10
            psp_in               <= pad_in[pdm_pkg::PIN_D:pdm_pkg::PIN_CCP]; // R6
        end
    end

    // configuration outputs
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            charge_unit_data_select <= 1'b0;
            analog_select           <= pdm_pkg::RST_ZERO;
        end else begin
            charge_unit_data_select <= pad_config_one_ff[pdm_pkg::PAD_CHARGE];
            analog_select           <= analog_select_high_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= pdm_pkg::RST_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                pdm_pkg::OFS_PIN_LEVELS:  reg_rdata <= port_d_pin_levels_ff;
                pdm_pkg::OFS_OUT_LATCH:   reg_rdata <= port_d_output_latch_ff;
                pdm_pkg::OFS_DIRECTION:   reg_rdata <= port_d_direction_ff;
                pdm_pkg::OFS_PAD_CONFIG:  reg_rdata <= pad_config_one_ff; // R11
                pdm_pkg::OFS_OPEN_DRAIN:  reg_rdata <= open_drain_control_ff;
                pdm_pkg::OFS_ANALOG_HIGH: reg_rdata <= analog_select_high_ff;
                pdm_pkg::OFS_MUX_CTRL:    reg_rdata <= mux_ctrl_ff;
                default:                  reg_rdata <= pdm_pkg::RST_ZERO;
            endcase
        end else begin
            reg_rdata <= pdm_pkg::RST_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_reset_inputs: assert property (@(posedge clk_sys) // R2
        srst |=> (pad_oe == pdm_pkg::RST_ZERO && pad_pullup == pdm_pkg::RST_ZERO))
        else $error("pins not inputs after reset");
    chk_dir_drive: assert property (@(posedge clk_sys) disable iff (srst) // R1
        !mux_ctrl_ff[pdm_pkg::MUX_PSP_EN] && !mux_ctrl_ff[pdm_pkg::MUX_PWM_EN]
        && !mux_ctrl_ff[pdm_pkg::MUX_SER_EN]
        |=> pad_oe == ~$past(port_d_direction_ff))
        else $error("pad enable does not follow direction");
    chk_psp_override: assert property (@(posedge clk_sys) disable iff (srst) // R6
        mux_ctrl_ff[pdm_pkg::MUX_PSP_EN] |=> pad_oe[7:4] == {4{$past(psp_drive)}}
        && pad_out[7:4] == $past(psp_out))
        else $error("slave port does not own upper pins");
    chk_pwm_shut: assert property (@(posedge clk_sys) disable iff (srst) // R4
        mux_ctrl_ff[pdm_pkg::MUX_PWM_EN] && mux_ctrl_ff[pdm_pkg::MUX_SHUT_TRI]
        && pwm_shutdown && !mux_ctrl_ff[pdm_pkg::MUX_PSP_EN] |=> pad_oe[5:4] == 2'h0)
        else $error("pwm not tri-stated on shutdown");
    chk_pwm_cd: assert property (@(posedge clk_sys) disable iff (srst) // R5
        mux_ctrl_ff[pdm_pkg::MUX_PWM_EN] && !mux_ctrl_ff[pdm_pkg::MUX_PSP_EN]
        && !mux_ctrl_ff[pdm_pkg::MUX_SER_EN] |=> pad_out[7:6] == $past(pwm_out[3:2]))
        else $error("pwm c or d not on pins");
    chk_serial_tx: assert property (@(posedge clk_sys) disable iff (srst) // R7
        mux_ctrl_ff[pdm_pkg::MUX_SER_EN] && !mux_ctrl_ff[pdm_pkg::MUX_SER_SYNC]
        && !mux_ctrl_ff[pdm_pkg::MUX_PSP_EN] |=> pad_out[6] == $past(ser_tx))
        else $error("serial transmit not on seventh pin");
    chk_rx_path: assert property (@(posedge clk_sys) disable iff (srst) // R9
        1'b1 |=> ser_rx_in == $past(pad_in[pdm_pkg::PIN_D]))
        else $error("receive input not fed from eighth pin");
    chk_pullup_off: assert property (@(posedge clk_sys) disable iff (srst) // R12
        pad_config_one_ff[pdm_pkg::PAD_D_PU] |=> pad_pullup == pdm_pkg::RST_ZERO)
        else $error("pull-ups not off");
    chk_pad_unimpl: assert property (@(posedge clk_sys) disable iff (srst) // R11
        variant == pdm_pkg::PDM_PKG_SMALL |=> pad_config_one_ff[7:4] == 4'h0)
        else $error("unimplemented pull-up bits not zero");
    chk_dir_reset: assert property (@(posedge clk_sys) // R2
        srst |=> port_d_direction_ff == pdm_pkg::RST_DIRECTION)
        else $error("direction not all inputs after reset");
    chk_mid_unimpl: assert property (@(posedge clk_sys) disable iff (srst) // R11
        variant == pdm_pkg::PDM_PKG_MID
        |=> pad_config_one_ff[pdm_pkg::PAD_F_PU:pdm_pkg::PAD_G_PU] == 2'h0)
        else $error("large-only pull-up bits not zero");

    // pin sampling into the port register and the capture input
    chk_pin_sample: assert property (@(posedge clk_sys) disable iff (srst) // R1
        1'b1 |=> port_d_pin_levels_ff == $past(pad_in))
        else $error("port register does not follow pins");
    chk_capture_in: assert property (@(posedge clk_sys) disable iff (srst) // R3
        1'b1 |=> ccp_capture_in == $past(pad_in[pdm_pkg::PIN_CCP]))
        else $error("capture input not fed from fifth pin");

    // peripheral outputs take the pins over latch data
    chk_ccp_out: assert property (@(posedge clk_sys) disable iff (srst) // R3
        mux_ctrl_ff[pdm_pkg::MUX_CCP_EN] && !mux_ctrl_ff[pdm_pkg::MUX_PWM_EN]
        && !mux_ctrl_ff[pdm_pkg::MUX_PSP_EN] |=> pad_out[pdm_pkg::PIN_CCP] == $past(ccp_out))
        else $error("compare output not on fifth pin");
    chk_pwm_ab: assert property (@(posedge clk_sys) disable iff (srst) // R4
        mux_ctrl_ff[pdm_pkg::MUX_PWM_EN] && !mux_ctrl_ff[pdm_pkg::MUX_PSP_EN]
        |=> pad_out[pdm_pkg::PIN_B:pdm_pkg::PIN_CCP] == $past(pwm_out[1:0]))
        else $error("pwm a or b not on pins");
    chk_sync_clock: assert property (@(posedge clk_sys) disable iff (srst) // R8
        mux_ctrl_ff[pdm_pkg::MUX_SER_EN] && mux_ctrl_ff[pdm_pkg::MUX_SER_SYNC]
        && !mux_ctrl_ff[pdm_pkg::MUX_PSP_EN] |=> pad_out[pdm_pkg::PIN_C] == $past(ser_clk_out)
        && pad_oe[pdm_pkg::PIN_C] == ~$past(port_d_direction_ff[pdm_pkg::PIN_C]))
        else $error("serial clock not on seventh pin");
    chk_sync_data: assert property (@(posedge clk_sys) disable iff (srst) // R10
        mux_ctrl_ff[pdm_pkg::MUX_SER_EN] && mux_ctrl_ff[pdm_pkg::MUX_SER_SYNC]
        && !mux_ctrl_ff[pdm_pkg::MUX_PSP_EN] |=> pad_out[pdm_pkg::PIN_D] == $past(ser_data_out)
        && pad_oe[pdm_pkg::PIN_D] == $past(ser_data_drive))
        else $error("serial data not on eighth pin");

    // a driven pin never has its pull-up on
    chk_pullup_output: assert property (@(posedge clk_sys) disable iff (srst) // R12
        1'b1 |=> (pad_pullup & pad_oe) == pdm_pkg::RST_ZERO)
        else $error("pull-up on while pin drives");

    // slave port enable written, then the selection, then the pads follow
    sequence seq_psp_enable_write;
        reg_wr && reg_addr == pdm_pkg::OFS_MUX_CTRL && reg_wdata[pdm_pkg::MUX_PSP_EN];
    endsequence
    sequence seq_psp_owns_pads;
        upper.psp_sel == 4'hF
        ##1 pad_oe[pdm_pkg::PIN_D:pdm_pkg::PIN_CCP] == {4{$past(psp_drive)}};
    endsequence
    chk_psp_takeover: assert property (@(posedge clk_sys) disable iff (srst) // R13
        seq_psp_enable_write |=> seq_psp_owns_pads)
        else $error("slave port did not take the upper pins");
endmodule

// ### pdm_port_mux_tb.sv
`timescale 1ns/1ps
module pdm_port_mux_tb;
    logic       clk_sys;
    logic       srst;
    logic [1:0] variant;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] pad_in;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pullup;
    logic [7:0] pad_open_drain;
    logic [3:0] pwm_out;
    logic [3:0] psp_out;
    logic [3:0] psp_in;
    logic [7:0] analog_select;
    logic       ccp_out, ccp_capture_in, pwm_shutdown, ser_tx, ser_clk_out;
    logic       ser_data_out, ser_data_drive, ser_clk_in, ser_rx_in, psp_drive, charge_sel;
    int         err_total;
    int         comparisons;
    logic [7:0] pcfg_exp [3] = '{8'h01, 8'hC1, 8'hF1};

    pdm_port_mux pdm_port_mux_i (
        .clk_sys(clk_sys), .srst(srst), .variant(variant), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .pad_open_drain(pad_open_drain), .ccp_out(ccp_out), .ccp_capture_in(ccp_capture_in),
        .pwm_out(pwm_out), .pwm_shutdown(pwm_shutdown), .ser_tx(ser_tx),
        .ser_clk_out(ser_clk_out), .ser_data_out(ser_data_out), .ser_data_drive(ser_data_drive),
        .ser_clk_in(ser_clk_in), .ser_rx_in(ser_rx_in), .psp_out(psp_out),
        .psp_drive(psp_drive), .psp_in(psp_in), .charge_unit_data_select(charge_sel),
        .analog_select(analog_select));

    ////////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // comparison and verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // register port master: one-cycle strobes, data the cycle after a read
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] msk);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata & msk, exp);
    endtask

    // let register and pad flops land
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic setup(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] mux);
        wr(pdm_pkg::OFS_DIRECTION, dir);
        wr(pdm_pkg::OFS_OUT_LATCH, lat);
        wr(pdm_pkg::OFS_MUX_CTRL, mux);
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset();
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        chk(pad_oe, 8'h00);
        chk(pad_pullup, 8'h00);
        rd(pdm_pkg::OFS_DIRECTION, 8'hFF, 8'hFF);
        rd(pdm_pkg::OFS_OUT_LATCH, 8'h00, 8'hFF);
        chk(pad_oe, 8'h00);
        $display("test reset done");
    endtask

    task automatic test_gpio();
        setup(8'h0F, 8'hA5, 8'h00);
        chk(pad_oe, 8'hF0);
        chk(pad_out & pad_oe, 8'hA0);
        wr(pdm_pkg::OFS_PIN_LEVELS, 8'h3C);
        rd(pdm_pkg::OFS_OUT_LATCH, 8'h3C, 8'hFF);
        @(posedge clk_sys);
        pad_in <= 8'h5A;
        #1;
        chk(reg_rdata, 8'h00);
        rd(pdm_pkg::OFS_PIN_LEVELS, 8'h0A, 8'h0F);
        rd(3'h7, 8'h00, 8'hFF);
        wr(pdm_pkg::OFS_PAD_CONFIG, 8'h00);
        settle();
        chk(pad_pullup, 8'h0F);
        wr(pdm_pkg::OFS_PAD_CONFIG, 8'h80);
        settle();
        chk(pad_pullup, 8'h00);
        $display("test gpio done");
    endtask

    task automatic test_pad_cfg();
        for (int v = 0; v < 3; v++) begin
            @(posedge clk_sys);
            variant <= v[1:0];
            wr(pdm_pkg::OFS_PAD_CONFIG, 8'hFF);
            rd(pdm_pkg::OFS_PAD_CONFIG, pcfg_exp[v], 8'hFF);
        end
        wr(pdm_pkg::OFS_ANALOG_HIGH, 8'hFF);
        wr(pdm_pkg::OFS_OPEN_DRAIN, 8'hA5);
        rd(pdm_pkg::OFS_ANALOG_HIGH, 8'h7F, 8'hFF);
        rd(pdm_pkg::OFS_OPEN_DRAIN, 8'hA5, 8'hFF);
        settle();
        chk(pad_open_drain, 8'hA5);
        chk(analog_select, 8'h7F);
        chk({7'h00, charge_sel}, 8'h01);
        $display("test pad config done");
    endtask

    task automatic test_ccp();
        @(posedge clk_sys);
        ccp_out <= 1'b1;
        setup(8'hEF, 8'h00, 8'h02);
        chk(pad_oe & 8'h10, 8'h10);
        chk(pad_out & 8'h10, 8'h10);
        @(posedge clk_sys);
        ccp_out <= 1'b0;
        wr(pdm_pkg::OFS_OUT_LATCH, 8'hFF);
        settle();
        chk(pad_out & 8'h10, 8'h00);
        wr(pdm_pkg::OFS_DIRECTION, 8'hFF);
        pad_in <= 8'h10;
        settle();
        chk({7'h00, ccp_capture_in}, 8'h01);
        $display("test capture compare done");
    endtask

    task automatic test_pwm();
        @(posedge clk_sys);
        ccp_out <= 1'b1;
        pwm_out <= 4'hA;
        setup(8'h0F, 8'h00, 8'h06);
        chk(pad_out & 8'hF0, 8'hA0);
        @(posedge clk_sys);
        pwm_shutdown <= 1'b1;
        settle();
        chk(pad_oe, 8'hF0);
        wr(pdm_pkg::OFS_MUX_CTRL, 8'h26);
        settle();
        chk(pad_oe & 8'hF0, 8'h00);
        @(posedge clk_sys);
        pwm_shutdown <= 1'b0;
        $display("test pwm done");
    endtask

    task automatic test_serial();
        @(posedge clk_sys);
        ser_tx  <= 1'b1;
        pwm_out <= 4'h0;
        setup(8'h0F, 8'h00, 8'h0C);
        chk(pad_out & 8'h40, 8'h40);
        wr(pdm_pkg::OFS_DIRECTION, 8'hFF);
        pad_in <= 8'h80;
        settle();
        chk({7'h00, ser_rx_in}, 8'h01);
        @(posedge clk_sys);
        ser_clk_out    <= 1'b1;
        ser_data_out   <= 1'b1;
        ser_data_drive <= 1'b1;
        setup(8'hBF, 8'h00, 8'h18);
        chk(pad_oe & 8'hC0, 8'hC0);
        chk(pad_out & 8'hC0, 8'hC0);
        @(posedge clk_sys);
        ser_data_drive <= 1'b0;
        pad_in         <= 8'h40;
        wr(pdm_pkg::OFS_DIRECTION, 8'hFF);
        settle();
        chk(pad_oe & 8'hC0, 8'h00);
        chk({7'h00, ser_clk_in}, 8'h01);
        $display("test serial done");
    endtask

    task automatic test_psp();
        @(posedge clk_sys);
        psp_drive <= 1'b1;
        psp_out   <= 4'h5;
        pwm_out   <= 4'hA;
        setup(8'hFF, 8'hF0, 8'h07);
        chk(pad_oe & 8'hF0, 8'hF0);
        chk(pad_out & 8'hF0, 8'h50);
        @(posedge clk_sys);
        psp_drive <= 1'b0;
        pad_in    <= 8'h90;
        wr(pdm_pkg::OFS_DIRECTION, 8'h00);
        settle();
        chk(pad_oe & 8'hF0, 8'h00);
        chk({4'h0, psp_in}, 8'h09);
        $display("test slave port done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        err_total      = 0;
        comparisons    = 0;
        srst           = 1'b1;
        variant        = 2'h2;
        reg_addr       = 3'h0;
        reg_wdata      = 8'h00;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        pad_in         = 8'h00;
        ccp_out        = 1'b0;
        pwm_out        = 4'h0;
        pwm_shutdown   = 1'b0;
        ser_tx         = 1'b0;
        ser_clk_out    = 1'b0;
        ser_data_out   = 1'b0;
        ser_data_drive = 1'b0;
        psp_out        = 4'h0;
        psp_drive      = 1'b0;
        test_reset();
        test_gpio();
        test_pad_cfg();
        test_ccp();
        test_pwm();
        test_serial();
        test_psp();
        test_done();
    end

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        test_done();
    end
endmodule
